// *** smpc_pkg.sv ***
// Package with register map, field layout and encodings of the sample mode and pin function control
package smpc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  MAIN_CONTROL_ADDR  = 8'h01;
    localparam logic [7:0]  PIN_DATA_ADDR      = 8'h1e;
    localparam logic [15:0] MAIN_CONTROL_RESET = 16'h0700;
    localparam logic [3:0]  PIN_DATA_RESET     = 4'h0;

    // ------------------------------------------------------------
    // Field positions inside main_control
    // ------------------------------------------------------------
    localparam int MODE_MSB  = 15;
    localparam int MODE_LSB  = 12;
    localparam int PIN2_MSB  = 11;
    localparam int PIN2_LSB  = 10;
    localparam int PIN1_MSB  = 9;
    localparam int PIN1_LSB  = 8;
    localparam int CHOFF_MSB = 7;
    localparam int CHOFF_LSB = 4;

    // Field positions inside the pin data register
    localparam int PD_IN1  = 0;
    localparam int PD_IN2  = 1;
    localparam int PD_OUT1 = 2;
    localparam int PD_OUT2 = 3;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SMPC_PIN_ALERT    = 2'h0,
        SMPC_PIN_GP_IN    = 2'h1,
        SMPC_PIN_GP_OUT   = 2'h2,
        SMPC_PIN_OVERRIDE = 2'h3
    } smpc_pin_fn_t;

    localparam logic [3:0] MODE_LAST_ADAPTIVE = 4'h3;
    localparam logic [3:0] MODE_LAST_PLAIN    = 4'h7;
    localparam logic [3:0] MODE_SINGLE        = 4'h8;
    localparam logic [3:0] MODE_SINGLE_AVG8   = 4'h9;
    localparam logic [3:0] MODE_FAST          = 4'ha;
    localparam logic [3:0] MODE_BURST         = 4'hb;
    localparam logic [3:0] MODE_SLEEP         = 4'hf;

    // Rate select: 0 fastest, 3 slowest (8 samples per second)
    localparam logic [1:0] RATE_SLOWEST = 2'h3;

endpackage

// *** smpc_pin_if.sv ***
// Interface carrying the control and status of one multi-purpose pin
`timescale 1ns/100ps
interface smpc_pin_if;
    smpc_pkg::smpc_pin_fn_t fn;
    logic                   out_val;
    logic                   alert_act;
    logic                   in_level;

    modport ctl (output fn, output out_val, output alert_act, input in_level);
    modport pin (input fn, input out_val, input alert_act, output in_level);
endinterface

// *** smpc_pin_unit.sv ***
// Pin unit: input synchroniser and drive control for one multi-purpose pin
`timescale 1ns/100ps
module smpc_pin_unit (
    input  wire logic core_clk,
    input  wire logic rst_n,
    smpc_pin_if.pin   pif,
    input  wire logic pin_i,
    output logic      pin_o_ff,
    output logic      pin_oe_ff
);

    logic sync1_ff;
    logic sync2_ff;

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    // Pin is asynchronous; only the second stage is looked at
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
        end
    end

    assign pif.in_level = sync2_ff;

    // ------------------------------------------------------------
    // Drive control
    // ------------------------------------------------------------
    // Alert pulls low open-drain style; output mode drives both levels
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_o_ff  <= 1'b0;
            pin_oe_ff <= 1'b0;
        end else begin
            case (pif.fn)
                smpc_pkg::SMPC_PIN_ALERT: begin
                    pin_o_ff  <= 1'b0;
                    pin_oe_ff <= pif.alert_act;
                end
                smpc_pkg::SMPC_PIN_GP_OUT: begin
                    pin_o_ff  <= pif.out_val;     // see RL8
                    pin_oe_ff <= 1'b1;
                end
                default: begin
                    // Input roles never drive, so no contention with the source
                    pin_o_ff  <= 1'b0;
                    pin_oe_ff <= 1'b0;
                end
            endcase
        end
    end

endmodule

// *** smpc_ctrl.sv ***
// Main control register upper byte: sample mode decode and multi-purpose pin roles
`timescale 1ns/100ps

// Behaviour
// RL1: Mode codes 0 to 3 are continuous sampling with adaptive accumulation at falling rates, code 0 the default.
// RL2: Mode codes 4 to 7 are continuous sampling at the same four rates without adaptive accumulation.
// RL3: Mode code 8 is single-shot and code 9 is single-shot with eight-fold averaging.
// RL4: Mode code 11 selects burst conversion.
// RL5: Mode codes 12 to 14 are reserved, the host must not write them and they produce no conversion behaviour.
// RL6: Mode code 15 is sleep with no sampling.
// RL7: The second pin role field selects alert, input, output or rate override.
// RL8: A pin in input role shows its sampled level to the host, in output role drives the written level.
// RL9: A rate-override pin held high forces the slowest rate of 8 samples per second.
// RL10: Only one pin should be the override; if both are, only the first pin counts.
// RL11: The first pin role field uses the same encoding as the second.
// RL12: The first pin in general-purpose roles shows its input level and drives its written level.
// RL13: Mode code 10 selects fast conversion.
// RL14: Pin input levels and output values live in a separate readable and writable data register.
module smpc_ctrl (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Register access from the serial front end
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata_ff,
    // Alert requests from the limit and conversion logic
    input  wire logic        alert1_req,
    input  wire logic        alert2_req,
    // Multi-purpose pins
    input  wire logic        pin1_i,
    output logic             pin1_o,
    output logic             pin1_oe,
    input  wire logic        pin2_i,
    output logic             pin2_o,
    output logic             pin2_oe,
    // Decoded conversion controls
    output logic             continuous_ff,
    output logic             adaptive_ff,
    output logic      [1:0]  rate_sel_ff,
    output logic             single_shot_ff,
    output logic             avg8_ff,
    output logic             fast_ff,
    output logic             burst_ff,
    output logic             sleep_ff,
    output logic      [3:0]  channel_off_ff
);

    // Stored fields of main_control and the pin data register
    logic [3:0]             mode_ff;
    smpc_pkg::smpc_pin_fn_t pin1_fn_ff;
    smpc_pkg::smpc_pin_fn_t pin2_fn_ff;
    logic                   out1_ff;
    logic                   out2_ff;
    // Combinational helpers
    logic                   override_hit;
    logic [15:0]            nxt_rdata;

    // One carrier per pin; the control side drives role, value and alert,
    // the pin unit hands back the synchronised level
    smpc_pin_if pin1_bus ();
    smpc_pin_if pin2_bus ();

    // Decides whether an access hits the given register
    // Kept as a function so the write and read decodes cannot drift apart
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        addr_hit = (addr == target);
    endfunction

    // ------------------------------------------------------------
    // main_control register
    // ------------------------------------------------------------
    // Reserved mode codes are stored as written; decode gives them no action
    // Roles take effect one edge after the write, outputs one edge later still
    // Bits 3:0 are not stored at all, so they cost no flops and read zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff        <= smpc_pkg::MAIN_CONTROL_RESET[smpc_pkg::MODE_MSB:smpc_pkg::MODE_LSB];  // see RL1
            pin2_fn_ff     <= smpc_pkg::smpc_pin_fn_t'(
                smpc_pkg::MAIN_CONTROL_RESET[smpc_pkg::PIN2_MSB:smpc_pkg::PIN2_LSB]);
            pin1_fn_ff     <= smpc_pkg::smpc_pin_fn_t'(
                smpc_pkg::MAIN_CONTROL_RESET[smpc_pkg::PIN1_MSB:smpc_pkg::PIN1_LSB]);
            channel_off_ff <= smpc_pkg::MAIN_CONTROL_RESET[smpc_pkg::CHOFF_MSB:smpc_pkg::CHOFF_LSB];
        end else if (reg_wr && addr_hit(reg_addr, smpc_pkg::MAIN_CONTROL_ADDR)) begin
            // Whole register written at once; no byte enables on this port
            mode_ff        <= reg_wdata[smpc_pkg::MODE_MSB:smpc_pkg::MODE_LSB];
            pin2_fn_ff     <= smpc_pkg::smpc_pin_fn_t'(reg_wdata[smpc_pkg::PIN2_MSB:smpc_pkg::PIN2_LSB]); // see RL7
            pin1_fn_ff     <= smpc_pkg::smpc_pin_fn_t'(reg_wdata[smpc_pkg::PIN1_MSB:smpc_pkg::PIN1_LSB]); // see RL11
            channel_off_ff <= reg_wdata[smpc_pkg::CHOFF_MSB:smpc_pkg::CHOFF_LSB];
        end
    end

    // ------------------------------------------------------------
    // Pin data register, output values
    // ------------------------------------------------------------
    // Output values are kept even while a pin is in another role
    // Input levels are not stored here: they are read live from the synchronisers
    // Bits 0 and 1 of a write are ignored, the pins own those levels
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out1_ff <= smpc_pkg::PIN_DATA_RESET[smpc_pkg::PD_OUT1];
            out2_ff <= smpc_pkg::PIN_DATA_RESET[smpc_pkg::PD_OUT2];
        end else if (reg_wr && addr_hit(reg_addr, smpc_pkg::PIN_DATA_ADDR)) begin
            // Only the two output bits are writable
            out1_ff <= reg_wdata[smpc_pkg::PD_OUT1];  // see RL14
            out2_ff <= reg_wdata[smpc_pkg::PD_OUT2];
        end
    end

    // ------------------------------------------------------------
    // Pin units
    // ------------------------------------------------------------
    // Alert requests pass straight through; they come from logic on this clock
    // and need no synchroniser, unlike the pad levels inside each unit
    assign pin1_bus.fn        = pin1_fn_ff;
    assign pin1_bus.out_val   = out1_ff;     // see RL12
    assign pin1_bus.alert_act = alert1_req;
    assign pin2_bus.fn        = pin2_fn_ff;
    assign pin2_bus.out_val   = out2_ff;     // see RL8
    assign pin2_bus.alert_act = alert2_req;

    // First multi-purpose pin
    smpc_pin_unit u_pin1 (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pif       (pin1_bus.pin),
        .pin_i     (pin1_i),
        .pin_o_ff  (pin1_o),
        .pin_oe_ff (pin1_oe)
    );

    // Second multi-purpose pin
    smpc_pin_unit u_pin2 (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pif       (pin2_bus.pin),
        .pin_i     (pin2_i),
        .pin_o_ff  (pin2_o),
        .pin_oe_ff (pin2_oe)
    );

    // ------------------------------------------------------------
    // Rate override
    // ------------------------------------------------------------
    // First pin has priority; second pin is only heard when first is not an override
    // A pin that is an override but held low leaves the programmed rate alone
    // Level passes two synchroniser flops, so a pad change reaches the rate
    // three edges later; a glitch shorter than a clock may be missed
    always_comb begin
        if (pin1_fn_ff == smpc_pkg::SMPC_PIN_OVERRIDE) begin
            override_hit = pin1_bus.in_level;  // see RL10
        end else if (pin2_fn_ff == smpc_pkg::SMPC_PIN_OVERRIDE) begin
            override_hit = pin2_bus.in_level;
        end else begin
            override_hit = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Registered so every control output comes straight from a flop
    // Costs one edge of latency after mode_ff, two after the write itself
    // Rate field is the low half of the mode code for all continuous codes;
    // for other codes it is passed on but the sampling logic ignores it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Nothing runs until the first edge after reset
            continuous_ff  <= 1'b0;
            adaptive_ff    <= 1'b0;
            rate_sel_ff    <= 2'h0;
            single_shot_ff <= 1'b0;
            avg8_ff        <= 1'b0;
            fast_ff        <= 1'b0;
            burst_ff       <= 1'b0;
            sleep_ff       <= 1'b0;
        end else begin
            // Continuous codes form one range, adaptive ones its lower half
            continuous_ff  <= (mode_ff <= smpc_pkg::MODE_LAST_PLAIN);             // see RL1
            adaptive_ff    <= (mode_ff <= smpc_pkg::MODE_LAST_ADAPTIVE);          // see RL1
            // Override forces the slowest rate in every mode, continuous or not
            rate_sel_ff    <= override_hit ? smpc_pkg::RATE_SLOWEST : mode_ff[1:0]; // see RL2 see RL9
            // Special modes each match a single code; single-shot matches both 8 and 9
            single_shot_ff <= (mode_ff == smpc_pkg::MODE_SINGLE) ||
                              (mode_ff == smpc_pkg::MODE_SINGLE_AVG8);            // see RL3
            avg8_ff        <= (mode_ff == smpc_pkg::MODE_SINGLE_AVG8);            // see RL3
            fast_ff        <= (mode_ff == smpc_pkg::MODE_FAST);                   // see RL13
            burst_ff       <= (mode_ff == smpc_pkg::MODE_BURST);                  // see RL4
            sleep_ff       <= (mode_ff == smpc_pkg::MODE_SLEEP);                  // see RL6
            // Codes 12 to 14 match none of the above: all mode flags low, rate still taken from the code, see RL5
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped addresses and unimplemented bits read as zero
    // Address is decoded in the same edge as the read strobe
    always_comb begin
        nxt_rdata = 16'h0000;
        if (addr_hit(reg_addr, smpc_pkg::MAIN_CONTROL_ADDR)) begin
            nxt_rdata[smpc_pkg::MODE_MSB:smpc_pkg::MODE_LSB]   = mode_ff;
            nxt_rdata[smpc_pkg::PIN2_MSB:smpc_pkg::PIN2_LSB]   = pin2_fn_ff;
            nxt_rdata[smpc_pkg::PIN1_MSB:smpc_pkg::PIN1_LSB]   = pin1_fn_ff;
            nxt_rdata[smpc_pkg::CHOFF_MSB:smpc_pkg::CHOFF_LSB] = channel_off_ff;
        end else if (addr_hit(reg_addr, smpc_pkg::PIN_DATA_ADDR)) begin
            // Inputs live, outputs as written
            nxt_rdata[smpc_pkg::PD_IN1]  = pin1_bus.in_level;  // see RL12
            nxt_rdata[smpc_pkg::PD_IN2]  = pin2_bus.in_level;  // see RL8
            nxt_rdata[smpc_pkg::PD_OUT1] = out1_ff;
            nxt_rdata[smpc_pkg::PD_OUT2] = out2_ff;
        end
    end

    // Read data is captured only on a read strobe and holds between reads,
    // so a slow front end may fetch it several cycles later
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;  // see RL14
        end
    end

endmodule

// *** smpc_ctrl_properties.sv ***
// Concurrent checks on the ports of the sample mode and pin function control
`timescale 1ns/100ps
module smpc_ctrl_properties (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata_ff,
    input wire logic        pin1_oe,
    input wire logic        pin2_oe,
    input wire logic        continuous_ff,
    input wire logic        adaptive_ff,
    input wire logic [1:0]  rate_sel_ff,
    input wire logic        single_shot_ff,
    input wire logic        avg8_ff,
    input wire logic        fast_ff,
    input wire logic        burst_ff,
    input wire logic        sleep_ff
);
    // ------------------------------------------------------------
    // Decode follows a control write by two edges
    // ------------------------------------------------------------
    logic       mw;
    logic [3:0] m;
    logic [1:0] mr;
    assign mw = reg_wr && (reg_addr == smpc_pkg::MAIN_CONTROL_ADDR);
    assign m  = reg_wdata[15:12];
    assign mr = reg_wdata[13:12];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    cont_mode_a: assert property (mw |-> ##2 continuous_ff == ($past(m, 2) <= 4'h7))
        else $error("continuous flag wrong");
    adapt_mode_a: assert property (mw |-> ##2 adaptive_ff == ($past(m, 2) <= 4'h3))
        else $error("adaptive flag wrong");
    single_mode_a: assert property (mw |-> ##2 single_shot_ff == ($past(m, 2) ==? 4'b100?)
        && avg8_ff == ($past(m, 2) == 4'h9)) else $error("single-shot flags wrong");
    fast_mode_a: assert property (mw |-> ##2 fast_ff == ($past(m, 2) == 4'ha))
        else $error("fast flag wrong");
    burst_mode_a: assert property (mw |-> ##2 burst_ff == ($past(m, 2) == 4'hb))
        else $error("burst flag wrong");
    sleep_mode_a: assert property (mw |-> ##2 sleep_ff == ($past(m, 2) == 4'hf))
        else $error("sleep flag wrong");
    resv_mode_a: assert property (mw && m inside {[4'hc:4'he]} |-> ##2 !(continuous_ff || adaptive_ff
        || single_shot_ff || avg8_ff || fast_ff || burst_ff || sleep_ff)) else $error("reserved code acts");
    rate_follow_a: assert property (mw && reg_wdata[11:8] == 4'h5 |-> ##2 rate_sel_ff == $past(mr, 2))
        else $error("rate select wrong");
    input_role_a: assert property (mw && reg_wdata[11:8] == 4'h5 |-> ##2 !pin1_oe && !pin2_oe)
        else $error("input pin driven");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_ff))
        else $error("read data moved without read");
endmodule

// *** smpc_host_model.sv ***
// Host side model driving the register strobe port of the control block
`timescale 1ns/100ps
module smpc_host_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] reg_rdata_ff,
    output logic      [7:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata
);
    // ------------------------------------------------------------
    // Bus tasks; reserved codes go out only when a scenario asks
    // ------------------------------------------------------------
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 16'h0000;
    end

    // Data inverted after the strobe so a stale bus never looks valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata_ff;
    endtask
endmodule

// *** smpc_ctrl_tb.sv ***
// Self-checking testbench of the sample mode and pin function control
`timescale 1ns/100ps
module smpc_ctrl_tb;
    localparam logic [7:0] MC = smpc_pkg::MAIN_CONTROL_ADDR;
    localparam logic [7:0] PD = smpc_pkg::PIN_DATA_ADDR;
    logic        core_clk, rst_n, reg_wr, reg_rd, alert1_req, alert2_req, ext1, ext2;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata_ff, rd_data;
    logic        pin1_o, pin1_oe, pin2_o, pin2_oe, continuous_ff, adaptive_ff;
    logic        single_shot_ff, avg8_ff, fast_ff, burst_ff, sleep_ff;
    logic [1:0]  rate_sel_ff;
    logic [3:0]  channel_off_ff;
    logic [6:0]  dec;
    int          num_errors, n_compared;
    assign dec = {continuous_ff, adaptive_ff, single_shot_ff, avg8_ff, fast_ff, burst_ff, sleep_ff};

    // Pads: driven level wins, otherwise the outside level
    smpc_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .alert1_req(alert1_req),
        .alert2_req(alert2_req), .pin1_i(pin1_oe ? pin1_o : ext1), .pin1_o(pin1_o), .pin1_oe(pin1_oe),
        .pin2_i(pin2_oe ? pin2_o : ext2), .pin2_o(pin2_o), .pin2_oe(pin2_oe), .continuous_ff(continuous_ff),
        .adaptive_ff(adaptive_ff), .rate_sel_ff(rate_sel_ff), .single_shot_ff(single_shot_ff),
        .avg8_ff(avg8_ff), .fast_ff(fast_ff), .burst_ff(burst_ff), .sleep_ff(sleep_ff),
        .channel_off_ff(channel_off_ff));
    smpc_host_model host_u (.core_clk(core_clk), .reg_rdata_ff(reg_rdata_ff), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Expected flags: continuous, adaptive, single, avg8, fast, burst, sleep
    function automatic logic [6:0] exp_dec(input logic [3:0] c);
        return {c <= 4'h7, c <= 4'h3, c ==? 4'b100?, c == 4'h9, c == 4'ha, c == 4'hb, c == 4'hf};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        repeat (2) @(posedge core_clk);
        chk(16'({dec, rate_sel_ff}), 16'({exp_dec(4'h0), 2'h0}));
        host_u.rd(MC, rd_data);
        chk(rd_data, 16'h0700);
        host_u.rd(PD, rd_data);
        chk(rd_data, 16'h0000);
    endtask

    // Every code, reserved ones too; low nibble written but reads zero
    task automatic t_modes();
        for (int c = 0; c < 16; c++) begin
            host_u.wr(MC, {4'(c), 12'h5f3});
            repeat (3) @(posedge core_clk);
            chk(16'({dec, rate_sel_ff}), 16'({exp_dec(4'(c)), 2'(c)}));
            host_u.rd(MC, rd_data);
            chk(rd_data, {4'(c), 12'h5f0});
            chk(16'(channel_off_ff), 16'h000f);
        end
    endtask

    // Both pins claim the override on purpose: only the first may count
    task automatic t_override();
        host_u.wr(MC, 16'h0f00);
        ext2 <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk(16'(rate_sel_ff), 16'h0000);
        ext1 <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk(16'({dec, rate_sel_ff}), 16'({exp_dec(4'h0), 2'h3}));
        host_u.wr(MC, 16'h0300);
        repeat (4) @(posedge core_clk);
        chk(16'(rate_sel_ff), 16'h0003);
        ext1 <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk(16'(rate_sel_ff), 16'h0000);
        // Second pin alone as override, first pin back to alert role
        host_u.wr(MC, 16'h0c00);
        repeat (4) @(posedge core_clk);
        chk(16'(rate_sel_ff), 16'h0003);
        ext1 <= 1'b1;
        ext2 <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk(16'(rate_sel_ff), 16'h0000);
    endtask

    task automatic t_gpio();
        host_u.wr(MC, 16'h0a00);
        host_u.wr(PD, 16'h0008);
        repeat (3) @(posedge core_clk);
        chk(16'({pin1_oe, pin1_o, pin2_oe, pin2_o}), 16'h000b);
        host_u.rd(PD, rd_data);
        chk(rd_data, 16'h000a);
        host_u.wr(PD, 16'h0004);
        repeat (3) @(posedge core_clk);
        chk(16'({pin1_oe, pin1_o, pin2_oe, pin2_o}), 16'h000e);
        host_u.wr(MC, 16'h0500);
        host_u.wr(PD, 16'h0003);
        repeat (4) @(posedge core_clk);
        chk(16'({pin1_oe, pin2_oe}), 16'h0000);
        host_u.rd(PD, rd_data);
        chk(rd_data, 16'h0001);
    endtask

    // Alert roles, then an unmapped write and read
    task automatic t_alert();
        host_u.wr(MC, 16'h0000);
        alert1_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(16'({pin1_oe, pin1_o, pin2_oe}), 16'h0004);
        alert1_req <= 1'b0;
        alert2_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(16'({pin1_oe, pin2_oe, pin2_o}), 16'h0002);
        host_u.wr(8'h55, 16'hffff);
        host_u.rd(8'h55, rd_data);
        chk(rd_data, 16'h0000);
        host_u.rd(MC, rd_data);
        chk(rd_data, 16'h0000);
    endtask

    // Hang guard well above the run length
    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        finish_test();
    end

    initial begin
        rst_n      = 1'b0;
        alert1_req = 1'b0;
        alert2_req = 1'b0;
        ext1       = 1'b0;
        ext2       = 1'b0;
        num_errors = 0;
        n_compared = 0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_modes();
        t_override();
        t_gpio();
        t_alert();
        finish_test();
    end
endmodule

bind smpc_ctrl smpc_ctrl_properties props_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .pin1_oe(pin1_oe),
    .pin2_oe(pin2_oe), .continuous_ff(continuous_ff), .adaptive_ff(adaptive_ff), .rate_sel_ff(rate_sel_ff),
    .single_shot_ff(single_shot_ff), .avg8_ff(avg8_ff), .fast_ff(fast_ff), .burst_ff(burst_ff),
    .sleep_ff(sleep_ff));
